// >>> rtl/ecl_defs.vh
/*
 * constants for the exception and low-power control block: register
 * offsets, field positions, reset values, vector codes and counts.
 * assumes it is included by bare name from the rtl files.
 */
`ifndef ECL_DEFS_VH
`define ECL_DEFS_VH

// register offsets on the plain register port
`define ECL_REG_CTRL 4'h0
`define ECL_REG_PFLAG 4'h1
`define ECL_REG_PEN 4'h2
`define ECL_REG_STATUS 4'h3

// control register fields and reset value
`define ECL_CTRL_DLY 0
`define ECL_CTRL_NOWD 1
`define ECL_CTRL_EDGE 2
`define ECL_CTRL_RESET 8'h01

// condition code flag positions
`define ECL_CCR_S 7
`define ECL_CCR_X 6
`define ECL_CCR_I 4

// vector codes; peripheral codes are their index
`define ECL_VEC_NONMASKABLE_REQUEST_PIN 5'h10
`define ECL_VEC_IRQ 5'h11
`define ECL_VEC_TRAP 5'h12
`define ECL_VEC_ILL 5'h13

// stacking: nine bytes, the flags byte last at eight below
`define ECL_STACK_LAST 4'h8
`define ECL_CCR_OFFSET 16'h0008

// oscillator restart delay in core clocks
`define ECL_RESTART_CYCLES 16'h1000

// implemented-opcode maps, one bit per opcode per page
`define ECL_OPMAP_DEFAULT {256{1'b1}}

`endif

// >>> rtl/ecl_stack_seq.v
/*
 * stacking sequencer: pushes nine bytes downward from a base address,
 * one per clock, selecting which cpu byte goes out at each step.
 * assumes the stack logic accepts one push per clock without stalling.
 */
`timescale 1ns/10ps
`include "ecl_defs.vh"

module ecl_stack_seq #(
	parameter AW = 16
) (
	input wire sys_clk,
	input wire reset,
	input wire start,
	input wire [AW-1:0] base_addr,
	output reg push_valid,
	output reg [AW-1:0] push_addr,
	output reg [3:0] push_sel,
	output reg done
);

reg busy_reg;
reg [3:0] idx_reg;
reg [AW-1:0] base_reg;

////////////////////////////////////////////////////////////////////////
// one byte per clock: pc low, pc high, y, x, a, b, flags last
always @(posedge sys_clk) begin
	if (reset) begin
		busy_reg <= 1'b0;
		idx_reg <= 4'h0;
		base_reg <= {AW{1'b0}};
		push_valid <= 1'b0;
		push_addr <= {AW{1'b0}};
		push_sel <= 4'h0;
		done <= 1'b0;
	end else begin
		done <= 1'b0;
		push_valid <= 1'b0;
		if (start && !busy_reg) begin
			busy_reg <= 1'b1;
			idx_reg <= 4'h0;
			base_reg <= base_addr;
		end else if (busy_reg) begin
			push_valid <= 1'b1;
			push_addr <= base_reg - {{(AW-4){1'b0}}, idx_reg};
			push_sel <= idx_reg;
			if (idx_reg == `ECL_STACK_LAST) begin
				busy_reg <= 1'b0;
				done <= 1'b1; // flags byte goes out with done
			end else begin
				idx_reg <= idx_reg + 4'h1;
			end
		end
	end
end

endmodule // ecl_stack_seq

// >>> rtl/ecl_exc_ctrl.v
/*
 * exception and low-power control for an 8-bit core: mask bits, request
 * priority, stacking, trap and illegal opcode entry, wait and stop modes.
 * assumes the sequencer pulses instr_boundary when an instruction ends
 * and gives op_trap, op_wait and op_stop with it; pins are asynchronous, active low.
 */
`timescale 1ns/10ps
`include "ecl_defs.vh"

module ecl_exc_ctrl #(
	parameter NPER = 8,
	parameter [15:0] RESTART_CYCLES = `ECL_RESTART_CYCLES,
	parameter [255:0] OPMAP_P0 = `ECL_OPMAP_DEFAULT,
	parameter [255:0] OPMAP_P1 = `ECL_OPMAP_DEFAULT,
	parameter [255:0] OPMAP_P2 = `ECL_OPMAP_DEFAULT,
	parameter [255:0] OPMAP_P3 = `ECL_OPMAP_DEFAULT
) (
	input wire sys_clk,
	input wire reset,
	input wire power_on_reset,
	input wire irq_pin_n,
	input wire nonmaskable_request_pin_n,
	input wire reset_pin_n,
	input wire [NPER-1:0] periph_event,
	input wire instr_boundary,
	input wire [1:0] opcode_page,
	input wire [7:0] opcode,
	input wire [15:0] opcode_addr,
	input wire [15:0] next_pc,
	input wire [15:0] stack_ptr,
	input wire op_trap,
	input wire op_wait,
	input wire op_stop,
	input wire op_rti,
	input wire [7:0] rti_flags,
	input wire op_flags_xfer,
	input wire [7:0] xfer_flags,
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	output wire ccr_s,
	output wire ccr_x,
	output wire ccr_i,
	output wire cpu_halt,
	output reg [15:0] return_addr,
	output wire push_valid,
	output wire [15:0] push_addr,
	output wire [3:0] push_sel,
	output reg vector_valid,
	output reg [4:0] vector_code,
	output reg wait_rd_valid,
	output reg [15:0] wait_rd_addr,
	output wire osc_enable,
	output wire clocks_halt,
	output wire timer1_halt,
	output reg core_reset_req,
	output reg resume_pulse,
	output wire wake_async
);

// one-hot states
localparam [5:0] ST_RUN = 6'h01;
localparam [5:0] ST_STACK = 6'h02;
localparam [5:0] ST_WAIT = 6'h04;
localparam [5:0] ST_STOP = 6'h08;
localparam [5:0] ST_RESTART = 6'h10;
localparam [5:0] ST_SERVE = 6'h20;

reg [5:0] state_reg;
reg s_reg;
reg x_reg;
reg i_reg;
reg [7:0] ctrl_reg;
reg [NPER-1:0] pflag_reg;
reg [NPER-1:0] pen_reg;
reg [2:0] pin_s1_reg;
reg [2:0] pin_s2_reg;
reg irq_prev_reg;
reg edge_pend_reg;
reg [4:0] pend_code_reg;
reg stack_wait_reg;
reg [15:0] dly_cnt_reg;
reg force_dly_reg;
reg stack_start_reg;
wire stack_done;
wire irq_lvl;
wire nonmaskable_request_pin_lvl;
wire rst_lvl;
wire irq_req;
wire nonmaskable_request_pin_req;
wire mask_req;
wire [NPER-1:0] per_req;
wire illegal_op;
reg [255:0] opmap;
reg [4:0] sel_code;
integer k;

assign ccr_s = s_reg;
assign ccr_x = x_reg;
assign ccr_i = i_reg;

////////////////////////////////////////////////////////////////////////
// pin synchronisers; the stop wake path below bypasses them
always @(posedge sys_clk) begin
	if (reset) begin
		pin_s1_reg <= 3'h7;
		pin_s2_reg <= 3'h7;
	end else begin
		pin_s1_reg <= {reset_pin_n, nonmaskable_request_pin_n, irq_pin_n};
		pin_s2_reg <= pin_s1_reg;
	end
end

assign irq_lvl = ~pin_s2_reg[0];
assign nonmaskable_request_pin_lvl = ~pin_s2_reg[1];
assign rst_lvl = ~pin_s2_reg[2];

// unclocked wake: valid while the oscillator is off in stop
assign wake_async = state_reg[3] & ((~irq_pin_n & ~i_reg) | ~nonmaskable_request_pin_n
	| ~reset_pin_n | (edge_pend_reg & ~i_reg));

////////////////////////////////////////////////////////////////////////
// request qualification and fixed priority
assign per_req = pflag_reg & pen_reg;
assign irq_req = ctrl_reg[`ECL_CTRL_EDGE] ? edge_pend_reg : irq_lvl;
assign nonmaskable_request_pin_req = nonmaskable_request_pin_lvl & ~x_reg;
assign mask_req = (irq_req | (|per_req)) & ~i_reg;

// nonmaskable first, then pin, then lowest peripheral index
always @* begin
	sel_code = `ECL_VEC_IRQ;
	for (k = NPER - 1; k >= 0; k = k - 1) begin
		if (per_req[k]) begin
			sel_code = k[4:0];
		end
	end
	if (irq_req) begin
		sel_code = `ECL_VEC_IRQ;
	end
	if (nonmaskable_request_pin_req) begin
		sel_code = `ECL_VEC_NONMASKABLE_REQUEST_PIN;
	end
end

////////////////////////////////////////////////////////////////////////
// illegal opcode lookup, one map per page
always @* begin
	case (opcode_page)
		2'h0: opmap = OPMAP_P0;
		2'h1: opmap = OPMAP_P1;
		2'h2: opmap = OPMAP_P2;
		default: opmap = OPMAP_P3;
	endcase
end

assign illegal_op = ~opmap[opcode];

////////////////////////////////////////////////////////////////////////
// peripheral flags: event sets, write-one clears, set wins
genvar g;
generate
	for (g = 0; g < NPER; g = g + 1) begin : g_flag
		always @(posedge sys_clk) begin
			if (reset) begin
				pflag_reg[g] <= 1'b0;
			end else if (periph_event[g]) begin
				pflag_reg[g] <= 1'b1;
			end else if (reg_wr && reg_addr == `ECL_REG_PFLAG && reg_wdata[g]) begin
				pflag_reg[g] <= 1'b0;
			end
		end
	end
endgenerate

////////////////////////////////////////////////////////////////////////
// edge-mode pin latch; cleared when its vector is issued
always @(posedge sys_clk) begin
	if (reset) begin
		irq_prev_reg <= 1'b0;
		edge_pend_reg <= 1'b0;
	end else begin
		irq_prev_reg <= irq_lvl;
		if (irq_lvl && !irq_prev_reg && ctrl_reg[`ECL_CTRL_EDGE]) begin
			edge_pend_reg <= 1'b1;
		end else if (vector_valid && vector_code == `ECL_VEC_IRQ) begin
			edge_pend_reg <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////
// register port: writes and one-cycle-late reads
always @(posedge sys_clk) begin
	if (reset) begin
		ctrl_reg <= `ECL_CTRL_RESET;
		pen_reg <= {NPER{1'b0}};
	end else if (reg_wr) begin
		if (reg_addr == `ECL_REG_CTRL) begin
			ctrl_reg <= reg_wdata;
		end
		if (reg_addr == `ECL_REG_PEN) begin
			pen_reg <= reg_wdata[NPER-1:0];
		end
	end
end

always @(posedge sys_clk) begin
	if (reset) begin
		reg_rdata <= 8'h00;
	end else if (reg_rd) begin
		case (reg_addr)
			`ECL_REG_CTRL: reg_rdata <= ctrl_reg;
			`ECL_REG_PFLAG: reg_rdata <= {{(8-NPER){1'b0}}, pflag_reg};
			`ECL_REG_PEN: reg_rdata <= {{(8-NPER){1'b0}}, pen_reg};
			`ECL_REG_STATUS: reg_rdata <= {state_reg, edge_pend_reg, nonmaskable_request_pin_req | mask_req};
			default: reg_rdata <= 8'h00;
		endcase
	end else begin
		reg_rdata <= 8'h00;
	end
end

////////////////////////////////////////////////////////////////////////
// stacking engine
ecl_stack_seq #(
	.AW(16)
) u_stack (
	.sys_clk(sys_clk),
	.reset(reset),
	.start(stack_start_reg),
	.base_addr(stack_ptr),
	.push_valid(push_valid),
	.push_addr(push_addr),
	.push_sel(push_sel),
	.done(stack_done)
);

////////////////////////////////////////////////////////////////////////
// sequencing of entry, wait, stop and restart
always @(posedge sys_clk) begin
	if (reset) begin
		state_reg <= ST_RUN;
		pend_code_reg <= `ECL_VEC_IRQ;
		stack_wait_reg <= 1'b0;
		stack_start_reg <= 1'b0;
		return_addr <= 16'h0000;
		vector_valid <= 1'b0;
		vector_code <= `ECL_VEC_IRQ;
		wait_rd_valid <= 1'b0;
		wait_rd_addr <= 16'h0000;
		dly_cnt_reg <= 16'h0000;
		force_dly_reg <= 1'b0;
		core_reset_req <= 1'b0;
		resume_pulse <= 1'b0;
	end else begin
		stack_start_reg <= 1'b0;
		vector_valid <= 1'b0;
		wait_rd_valid <= 1'b0;
		core_reset_req <= 1'b0;
		resume_pulse <= 1'b0;
		if (power_on_reset) begin
			state_reg <= ST_RESTART;
			force_dly_reg <= 1'b1;
			dly_cnt_reg <= 16'h0000;
		end else begin
			case (state_reg)
				ST_RUN: begin
					if (instr_boundary) begin
						if (illegal_op) begin
							pend_code_reg <= `ECL_VEC_ILL;
							return_addr <= opcode_addr;
							stack_wait_reg <= 1'b0;
							stack_start_reg <= 1'b1;
							state_reg <= ST_STACK;
						end else if (op_trap) begin
							pend_code_reg <= `ECL_VEC_TRAP;
							return_addr <= next_pc;
							stack_wait_reg <= 1'b0;
							stack_start_reg <= 1'b1;
							state_reg <= ST_STACK;
						end else if (op_wait) begin
							return_addr <= next_pc;
							stack_wait_reg <= 1'b1;
							stack_start_reg <= 1'b1;
							wait_rd_addr <= stack_ptr - `ECL_CCR_OFFSET;
							state_reg <= ST_STACK;
						end else if (op_stop && !s_reg) begin
							return_addr <= next_pc;
							state_reg <= ST_STOP;
						end else if (nonmaskable_request_pin_req || mask_req) begin
							pend_code_reg <= sel_code;
							return_addr <= next_pc;
							stack_wait_reg <= 1'b0;
							stack_start_reg <= 1'b1;
							state_reg <= ST_STACK;
						end
					end
				end
				ST_STACK: begin
					if (stack_done) begin
						state_reg <= stack_wait_reg ? ST_WAIT : ST_SERVE;
					end
				end
				ST_WAIT: begin
					wait_rd_valid <= 1'b1;
					if (nonmaskable_request_pin_req || mask_req) begin
						pend_code_reg <= sel_code;
						state_reg <= ST_SERVE;
					end
				end
				ST_SERVE: begin
					vector_valid <= 1'b1;
					vector_code <= pend_code_reg;
					state_reg <= ST_RUN;
				end
				ST_STOP: begin
					if (rst_lvl) begin
						core_reset_req <= 1'b1;
						force_dly_reg <= 1'b1;
						dly_cnt_reg <= 16'h0000;
						state_reg <= ST_RESTART;
					end else if (nonmaskable_request_pin_lvl || ((irq_lvl || edge_pend_reg) && !i_reg)) begin
						force_dly_reg <= 1'b0;
						dly_cnt_reg <= 16'h0000;
						state_reg <= ST_RESTART;
					end
				end
				ST_RESTART: begin
					if ((ctrl_reg[`ECL_CTRL_DLY] || force_dly_reg)
						&& dly_cnt_reg != RESTART_CYCLES - 16'h0001) begin
						dly_cnt_reg <= dly_cnt_reg + 16'h0001;
					end else begin
						force_dly_reg <= 1'b0;
						resume_pulse <= 1'b1;
						state_reg <= ST_RUN;
					end
				end
				default: state_reg <= ST_RUN;
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////
// condition code masks: entry sets win over return and transfer
always @(posedge sys_clk) begin
	if (reset) begin
		s_reg <= 1'b1;
		x_reg <= 1'b1;
		i_reg <= 1'b1;
	end else if (state_reg[5]) begin
		i_reg <= 1'b1;
		if (pend_code_reg == `ECL_VEC_NONMASKABLE_REQUEST_PIN) begin
			x_reg <= 1'b1;
		end
	end else if (op_rti && state_reg[0]) begin
		s_reg <= rti_flags[`ECL_CCR_S];
		x_reg <= rti_flags[`ECL_CCR_X];
		i_reg <= rti_flags[`ECL_CCR_I];
	end else if (op_flags_xfer && state_reg[0]) begin
		s_reg <= xfer_flags[`ECL_CCR_S];
		x_reg <= x_reg & xfer_flags[`ECL_CCR_X];
		i_reg <= xfer_flags[`ECL_CCR_I];
	end
end

////////////////////////////////////////////////////////////////////////
// power controls; in stop nothing changes so state is kept
assign cpu_halt = ~state_reg[0];
assign osc_enable = ~state_reg[3];
assign clocks_halt = state_reg[3];
assign timer1_halt = state_reg[3] | (state_reg[2] & i_reg & ctrl_reg[`ECL_CTRL_NOWD]);

endmodule // ecl_exc_ctrl

// >>> test/ecl_exc_ctrl_monitor.sv
/* assertions on the ports of the exception controller.
   assumes one core clock and a synchronous active-high reset. */
`timescale 1ns/10ps
`include "ecl_defs.vh"
////////////////////////////////////////
module ecl_exc_monitor (
	input logic sys_clk,
	input logic reset,
	input logic instr_boundary,
	input logic op_stop,
	input logic op_rti,
	input logic [7:0] rti_flags,
	input logic op_flags_xfer,
	input logic [7:0] xfer_flags,
	input logic ccr_s,
	input logic ccr_x,
	input logic ccr_i,
	input logic cpu_halt,
	input logic push_valid,
	input logic [15:0] push_addr,
	input logic [3:0] push_sel,
	input logic vector_valid,
	input logic [4:0] vector_code,
	input logic wait_rd_valid,
	input logic [15:0] wait_rd_addr,
	input logic osc_enable,
	input logic clocks_halt,
	input logic timer1_halt
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	logic [15:0] flags_addr;
	// where the flags byte went; wait reads must aim there
	always_ff @(posedge sys_clk)
		if (push_valid && push_sel == 4'h8)
			flags_addr <= push_addr;
	////////////////////////////////////////
	property p_rst; disable iff (1'b0) reset |=> ccr_x && ccr_i; endproperty
	a_rst: assert property (p_rst) else $error("masks not set by reset");
	property p_xset; $rose(ccr_x) |-> $past(op_rti) ||
		(vector_valid && vector_code == `ECL_VEC_NONMASKABLE_REQUEST_PIN); endproperty
	a_xset: assert property (p_xset) else $error("x set without entry");
	property p_xfer; op_flags_xfer && !cpu_halt && !instr_boundary |=>
		ccr_x == ($past(ccr_x) && $past(xfer_flags[6])) && ccr_i == $past(xfer_flags[4]);
	endproperty
	a_xfer: assert property (p_xfer) else $error("flag transfer wrong");
	property p_rti; op_rti && !cpu_halt && !instr_boundary |=>
		ccr_x == $past(rti_flags[6]) && ccr_i == $past(rti_flags[4]); endproperty
	a_rti: assert property (p_rti) else $error("return masks wrong");
	property p_vec; vector_valid |-> ccr_i &&
		(vector_code != `ECL_VEC_NONMASKABLE_REQUEST_PIN || ccr_x); endproperty
	a_vec: assert property (p_vec) else $error("entry masks not set");
	property p_xkeep; vector_valid && vector_code != `ECL_VEC_NONMASKABLE_REQUEST_PIN |->
		ccr_x == $past(ccr_x, 2); endproperty
	a_xkeep: assert property (p_xkeep) else $error("x changed by entry");
	property p_push; push_valid && push_sel == 4'h0 |-> ##8 push_valid &&
		push_sel == 4'h8 && push_addr == $past(push_addr, 8) - 16'h0008; endproperty
	a_push: assert property (p_push) else $error("stacking order wrong");
	// boundary edge, then sequencer start, then busy, then the first push
	property p_lat; $rose(push_valid) |-> $past(instr_boundary, 3); endproperty
	a_lat: assert property (p_lat) else $error("entry off boundary");
	property p_wait; wait_rd_valid |-> wait_rd_addr == flags_addr && osc_enable;
	endproperty
	a_wait: assert property (p_wait) else $error("wait read wrong");
	property p_stop; instr_boundary && op_stop && !cpu_halt |=>
		clocks_halt == !$past(ccr_s); endproperty
	a_stop: assert property (p_stop) else $error("stop gating wrong");
	property p_halt; clocks_halt |-> !osc_enable && !push_valid && !vector_valid &&
		timer1_halt; endproperty
	a_halt: assert property (p_halt) else $error("activity in stop");
endmodule // ecl_exc_monitor
////////////////////////////////////////
bind ecl_exc_ctrl ecl_exc_monitor mon_u (.sys_clk, .reset, .instr_boundary, .op_stop,
	.op_rti, .rti_flags, .op_flags_xfer, .xfer_flags, .ccr_s, .ccr_x, .ccr_i, .cpu_halt,
	.push_valid, .push_addr, .push_sel, .vector_valid, .vector_code, .wait_rd_valid,
	.wait_rd_addr, .osc_enable, .clocks_halt, .timer1_halt);

// >>> test/ecl_pin_model.sv
/* request sources: active-low request pins and event pulses.
   assumes commands change just after a clock edge. */
`timescale 1ns/10ps
////////////////////////////////////////
module ecl_pin_model (
	input logic sys_clk,
	input logic req_irq,
	input logic req_nmi,
	input logic req_rst,
	input logic ev_go,
	input logic [2:0] ev_idx,
	output logic irq_pin_n,
	output logic nonmaskable_request_pin_n,
	output logic reset_pin_n,
	output logic [7:0] periph_event
);
	// each pin driven straight from its request, low while requested and high otherwise
	assign irq_pin_n = !req_irq;
	assign nonmaskable_request_pin_n = !req_nmi;
	assign reset_pin_n = !req_rst;
	// one-cycle event on the chosen flag
	always @(posedge sys_clk)
		periph_event <= ev_go ? 8'h01 << ev_idx : 8'h00;
endmodule // ecl_pin_model

// >>> test/test_cpu_exception_and_low_power_control.sv
/* bench for the exception controller: core side and register port driven
   here, pins by the pin model; vectors and reads checked from queues.
   assumes a short restart count and page 1 opcode 00 unimplemented. */
`timescale 1ns/10ps
////////////////////////////////////////
module test_cpu_exception_and_low_power_control;
	logic sys_clk, reset, power_on_reset, instr_boundary, op_trap, op_wait, op_stop;
	logic op_rti, op_flags_xfer, reg_wr, reg_rd, rd_d, vector_valid, ccr_s, ccr_x, ccr_i;
	logic cpu_halt, clocks_halt, core_reset_req, resume_pulse, irq_pin_n, reset_pin_n;
	logic nonmaskable_request_pin_n, req_irq, req_nmi, req_rst, ev_go, timer1_halt, wake_async;
	logic [1:0] opcode_page;
	logic [2:0] ev_idx, k;
	logic [3:0] reg_addr;
	logic [4:0] vector_code;
	logic [7:0] opcode, rti_flags, xfer_flags, reg_wdata, reg_rdata, periph_event;
	logic [15:0] opcode_addr, next_pc, stack_ptr, return_addr;
	logic [20:0] vq[$];
	logic [7:0] rq[$];
	int n_errors, tests_run, cyc, t0, n1;
	ecl_exc_ctrl #(.RESTART_CYCLES(16'h0008), .OPMAP_P1(~256'h1)) dut_u (.sys_clk, .reset,
		.power_on_reset, .irq_pin_n, .nonmaskable_request_pin_n, .reset_pin_n,
		.periph_event, .instr_boundary, .opcode_page, .opcode, .opcode_addr, .next_pc,
		.stack_ptr, .op_trap, .op_wait, .op_stop, .op_rti, .rti_flags, .op_flags_xfer,
		.xfer_flags, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ccr_s, .ccr_x,
		.ccr_i, .cpu_halt, .return_addr, .push_valid(), .push_addr(), .push_sel(),
		.vector_valid, .vector_code, .wait_rd_valid(), .wait_rd_addr(), .osc_enable(),
		.clocks_halt, .timer1_halt, .core_reset_req, .resume_pulse, .wake_async);
	ecl_pin_model pin_u (.sys_clk, .req_irq, .req_nmi, .req_rst, .ev_go, .ev_idx,
		.irq_pin_n, .nonmaskable_request_pin_n, .reset_pin_n, .periph_event);
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////
	task chk_vec(input logic [20:0] got, input logic [20:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: vector %h expected %h", $time, got, exp);
		end
	endtask
	task chk_val(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: value %h expected %h", $time, got, exp);
		end
	endtask
	task wrap_up;
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// watcher: every vector and read answer must match the oldest note
	always @(posedge sys_clk) begin
		rd_d <= reg_rd;
		if (vector_valid === 1'b1)
			chk_vec({vector_code, return_addr}, vq.size() ? vq.pop_front() : 21'h1fffff);
		if (rd_d === 1'b1)
			chk_val(reg_rdata, rq.pop_front());
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			wrap_up;
		end
	end
	////////////////////////////////////////
	task tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task rreg(input logic [3:0] a, input logic [7:0] e);
		rq.push_back(e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
	endtask
	// instruction end with {trap, wait, stop} strobes; fresh addresses each time
	task bnd(input logic [2:0] ops, input logic [1:0] pg, input logic [7:0] opc);
		@(posedge sys_clk);
		{op_trap, op_wait, op_stop} <= ops;
		opcode_page <= pg;
		opcode <= opc;
		opcode_addr <= 16'($urandom);
		next_pc <= 16'($urandom);
		stack_ptr <= 16'h8000 | 16'($urandom);
		instr_boundary <= 1'b1;
		@(posedge sys_clk);
		instr_boundary <= 1'b0;
		{op_trap, op_wait, op_stop} <= 3'h0;
	endtask
	// rti or flag transfer; returns once the masks have landed
	task flags(input logic rti, input logic [7:0] f);
		@(posedge sys_clk);
		op_rti <= rti;
		op_flags_xfer <= !rti;
		rti_flags <= f;
		xfer_flags <= f;
		@(posedge sys_clk);
		{op_rti, op_flags_xfer} <= 2'h0;
		@(posedge sys_clk);
	endtask
	task settle;
		t0 = 0;
		tick(2);
		while (cpu_halt !== 1'b0 && t0 < 300) begin
			@(posedge sys_clk);
			t0++;
		end
		tick(2);
	endtask
	task waitres;
		t0 = 0;
		while (resume_pulse !== 1'b1 && core_reset_req !== 1'b1 && t0 < 60) begin
			@(posedge sys_clk);
			t0++;
		end
	endtask
	task stopwake(input logic [2:0] r);
		bnd(3'b001, 2'h0, 8'h01);
		tick(3);
		{req_rst, req_nmi, req_irq} <= r;
		waitres;
	endtask
	// pending request, pin or peripheral, taken at the next boundary, then serviced
	task take(input logic [4:0] code);
		bnd(3'h0, 2'h0, 8'h01);
		vq.push_back({code, next_pc});
		settle;
	endtask
	////////////////////////////////////////
	initial begin
		void'($urandom(32'h0be5));
		{reset, power_on_reset} = 2'h3;
		{instr_boundary, op_trap, op_wait, op_stop, op_rti, op_flags_xfer} = 6'h0;
		{reg_wr, reg_rd, req_irq, req_nmi, req_rst, ev_go} = 6'h0;
		{opcode_page, opcode, rti_flags, xfer_flags, reg_wdata, reg_addr} = 38'h0;
		{opcode_addr, next_pc, stack_ptr, ev_idx} = 51'h0;
		tick(16);
		reset <= 1'b0;
		tick(1);
		power_on_reset <= 1'b0;
		settle;
		// power-on restart of eight cycles; settle counts seven of them
		chk_val(8'(t0), 8'h07);
		chk_val(8'({ccr_s, ccr_x, ccr_i}), 8'h7);
		rreg(4'h0, 8'h01);
		rreg(4'hf, 8'h00);
		bnd(3'b100, 2'h0, 8'h01);
		vq.push_back({5'h12, next_pc});
		settle;
		flags(1'b0, 8'h00);
		flags(1'b0, 8'h40);
		chk_val(8'({ccr_s, ccr_x, ccr_i}), 8'h0);
		{req_nmi, req_irq} <= 2'h3;
		tick(3);
		take(5'h10);
		req_nmi <= 1'b0;
		flags(1'b1, 8'h00);
		take(5'h11);
		req_irq <= 1'b0;
		flags(1'b1, 8'h00);
		k = 3'($urandom % 8);
		wreg(4'h2, 8'h01 << k);
		ev_idx <= k;
		ev_go <= 1'b1;
		tick(1);
		ev_go <= 1'b0;
		tick(3);
		take({2'h0, k});
		flags(1'b1, 8'h00);
		take({2'h0, k});
		wreg(4'h1, 8'h01 << k);
		flags(1'b1, 8'h00);
		bnd(3'h0, 2'h0, 8'h01);
		settle;
		bnd(3'h0, 2'h1, 8'h00);
		vq.push_back({5'h13, opcode_addr});
		settle;
		flags(1'b1, 8'h00);
		wreg(4'h0, 8'h03); // watchdog off, so only the global mask decides
		bnd(3'b010, 2'h0, 8'h01);
		vq.push_back({5'h11, next_pc});
		tick(20);
		chk_val(8'(cpu_halt), 8'h1);
		chk_val(8'(timer1_halt), 8'h00);
		req_irq <= 1'b1;
		settle;
		req_irq <= 1'b0;
		flags(1'b1, 8'h00);
		flags(1'b0, 8'h80);
		bnd(3'b001, 2'h0, 8'h01);
		tick(2);
		chk_val(8'(clocks_halt), 8'h0);
		flags(1'b0, 8'h00);
		stopwake(3'b001);
		n1 = t0;
		take(5'h11);
		req_irq <= 1'b0;
		flags(1'b1, 8'h00);
		wreg(4'h0, 8'h00);
		stopwake(3'b001);
		chk_val(8'(n1 - t0), 8'h07);
		take(5'h11);
		req_irq <= 1'b0;
		flags(1'b1, 8'h00);
		stopwake(3'b010);
		take(5'h10);
		req_nmi <= 1'b0;
		stopwake(3'b001);
		chk_val(8'(t0), 8'h3c);
		chk_val(8'(wake_async), 8'h00);
		req_nmi <= 1'b1;
		tick(1);
		chk_val(8'(wake_async), 8'h01);
		waitres;
		chk_val(8'(t0 < 60), 8'h1);
		{req_nmi, req_irq} <= 2'h0;
		bnd(3'h0, 2'h0, 8'h01);
		flags(1'b1, 8'h00);
		// edge mode: a short low pulse must stay pending after the pin is back high
		wreg(4'h0, 8'h04);
		req_irq <= 1'b1;
		tick(3);
		req_irq <= 1'b0;
		tick(3);
		take(5'h11);
		stopwake(3'b100);
		chk_val(8'(core_reset_req), 8'h1);
		req_rst <= 1'b0;
		reset <= 1'b1;
		tick(16);
		reset <= 1'b0;
		settle;
		chk_val(8'(t0), 8'h00);
		chk_val(8'({ccr_x, ccr_i}), 8'h3);
		rreg(4'h0, 8'h01);
		tick(3);
		wrap_up;
	end
endmodule // test_cpu_exception_and_low_power_control
